// ===== include/tx_spi_pkg.sv
// Constants for the transmitter serial port and power control
// Behaviour
// - Register writes accepted in every power state
// - One 16-bit frame per select-low period
// - Frame order: D0-D7, A0-A6, direction bit
// - Direction 0 reads, 1 writes data byte
// - Read returns seven status bits, then data
// - Status: lock, over, under, full, empty, fill
// - Status shown on output during every access
// - Four-bit power field selects operating parts
// - Deep sleep: registers kept, slow access
// - Regulator idle: core nominal, rest off, full speed access
// - Oscillator idle: crystal on, transmitter off
// - Settling: synthesizer on, output stays off
// - Bit maps for amplitude, frequency, phase keying
// - Four-level symbols map to -3,-1,+1,+3
// - DSSS framing spreads each bit 15 chips
// - Minimum shift keying is frequency keying h=0.5
package tx_spi_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS    = 16;
    localparam int DATA_LSB      = 0;
    localparam int ADDR_LSB      = 8;
    localparam int DIR_BIT       = 15;
    localparam int STATUS_BITS   = 7;
    localparam int RDATA_FIRST   = 8;

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_SCRATCH    = 7'h01;
    localparam logic [6:0] ADDR_POWER      = 7'h02;
    localparam logic [6:0] ADDR_MODULATION = 7'h10;
    localparam logic [6:0] ADDR_FRAMING    = 7'h12;
    localparam logic [7:0] RST_SCRATCH     = 8'h00;
    localparam logic [3:0] RST_POWER       = 4'h0;
    localparam logic [2:0] RST_MODULATION  = 3'h0;
    localparam int         DSSS_EN_BIT     = 0;

    // ------------------------------------------------------------
    // Power state codes
    // ------------------------------------------------------------
    localparam logic [3:0] deep_sleep          = 4'h0;
    localparam logic [3:0] regulator_on_idle   = 4'h4;
    localparam logic [3:0] osc_idle_state      = 4'h5;
    localparam logic [3:0] synth_settle_state  = 4'hc;
    localparam logic [3:0] full_transmit_state = 4'hd;

    // ------------------------------------------------------------
    // Modulation codes and spreading
    // ------------------------------------------------------------
    localparam logic [2:0] MOD_ASK  = 3'h0;
    localparam logic [2:0] MOD_PSK  = 3'h1;
    localparam logic [2:0] MOD_FSK  = 3'h2;
    localparam logic [2:0] MOD_MSK  = 3'h3;
    localparam logic [2:0] MOD_FSK4 = 3'h4;
    localparam int         SPREAD_FACTOR = 15;
    localparam logic [3:0] PN_SEED       = 4'h1;

endpackage : tx_spi_pkg

// ===== design/tx_symbol_mapper.sv
// Combinational bit/symbol to modulator control map
`timescale 1ns/1ps
module tx_symbol_mapper
    import tx_spi_pkg::*;
(
    input  wire logic       i_enable,       // Transmitter running
    input  wire logic [2:0] i_mod_type,     // Modulation code
    input  wire logic [1:0] i_symbol,       // Bit in [0], 4-level uses [1:0]
    output logic            o_pa_on,        // Power amplifier on
    output logic signed [2:0] o_deviation,  // Deviation in units of f_dev
    output logic            o_phase_flip    // 180 degree phase step
);

    // ------------------------------------------------------------
    // Symbol map
    // ------------------------------------------------------------
    always_comb
    begin
        o_pa_on      = 1'b0;
        o_deviation  = 3'sd0;
        o_phase_flip = 1'b0;
        if (i_enable)
        begin
            case (i_mod_type)
                MOD_ASK:
                begin
                    o_pa_on = i_symbol[0];
                end
                MOD_PSK:
                begin
                    o_pa_on      = 1'b1;
                    o_phase_flip = i_symbol[0];
                end
                // MSK as frequency keying; deviation scaling is external
                MOD_FSK, MOD_MSK:
                begin
                    o_pa_on     = 1'b1;
                    o_deviation = i_symbol[0] ? 3'sd1 : -3'sd1;
                end
                MOD_FSK4:
                begin
                    o_pa_on = 1'b1;
                    case (i_symbol)
                        2'h0:    o_deviation = -3'sd3;
                        2'h1:    o_deviation = -3'sd1;
                        2'h2:    o_deviation = 3'sd1;
                        default: o_deviation = 3'sd3;
                    endcase
                end
                // Unused codes keep the amplifier off
                default:
                begin
                    o_pa_on = 1'b0;
                end
            endcase
        end
    end

endmodule : tx_symbol_mapper

// ===== design/tx_spi_port.sv
// Serial register port, power state control and transmit bit path
`timescale 1ns/1ps
module tx_spi_port
    import tx_spi_pkg::*;
#(
    parameter int SPREAD = SPREAD_FACTOR   // Chips per user bit in DSSS mode
)
(
    input  wire logic        i_core_clk,        // Core clock, 20 MHz
    input  wire logic        i_reset,           // Synchronous reset, high
    input  wire logic        i_sclk,            // Serial clock from host
    input  wire logic        i_sel_n,           // Frame select, active low
    input  wire logic        i_mosi,            // Host to device data
    output logic             o_miso,            // Device to host data
    output logic             o_miso_oe,         // Drive enable for o_miso
    input  wire logic        i_synth_lock,      // Synthesizer locked
    input  wire logic        i_fifo_over,       // FIFO overrun flag
    input  wire logic        i_fifo_under,      // FIFO underrun flag
    input  wire logic        i_fifo_full,       // FIFO full flag
    input  wire logic        i_fifo_empty,      // FIFO empty flag
    input  wire logic [1:0]  i_fifo_fill_code,  // FIFO fill/status code
    input  wire logic        i_symbol_tick,     // Symbol or chip strobe
    input  wire logic [1:0]  i_tx_bits,         // Next user bit(s)
    output logic             o_bit_take,        // Pulse: user bit consumed
    output logic             o_core_nominal,    // Core voltage at nominal
    output logic             o_serial_slow,     // Serial access slowed
    output logic             o_osc_en,          // Crystal oscillator on
    output logic             o_synth_en,        // Synthesizer on
    output logic             o_tx_en,           // Transmitter on
    output logic             o_pa_on,           // Amplifier keyed on
    output logic signed [2:0] o_deviation,      // Frequency step
    output logic             o_phase_flip       // Phase step 180 degrees
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (SPREAD < 2 || SPREAD > 15)
    begin : g_bad_spread
        $error("SPREAD must lie in 2..15");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        sclk_prev;    // Serial clock one cycle ago
        logic [15:0] shift;        // Incoming frame bits
        logic [4:0]  cnt;          // Bits taken this frame
        logic [6:0]  status;       // Status frozen at frame start
        logic [7:0]  rdata;        // Data staged for next read frame
        logic        miso;
        logic        miso_oe;
        logic [7:0]  scratch;      // Free scratch register
        logic [3:0]  power;        // power_state_select
        logic [2:0]  modulation;   // Modulation code
        logic        dsss_en;      // Spreading enable
        logic [3:0]  pn;           // Spreading sequence state
        logic [3:0]  chip;         // Chip index within a user bit
        logic [1:0]  sym;          // Symbol held for the mapper
        logic        bit_take;
        logic        core_nominal;
        logic        serial_slow;
        logic        osc_en;
        logic        synth_en;
        logic        tx_en;
        logic        pa_on;
        logic [2:0]  deviation;
        logic        phase_flip;
    } state_t;

    state_t s_q;                   // Registered state
    state_t s_d;                   // Next state

    logic             map_pa;      // Mapper outputs
    logic signed [2:0] map_dev;
    logic             map_flip;

    // ------------------------------------------------------------
    // Register read decode, shared by frame end
    // ------------------------------------------------------------
    function automatic logic [7:0] reg_read(input state_t s, input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ADDR_SCRATCH:    v = s.scratch;
            ADDR_POWER:      v = {4'h0, s.power};
            ADDR_MODULATION: v = {5'h00, s.modulation};
            ADDR_FRAMING:    v = {7'h00, s.dsss_en};
            default:         v = 8'h00;   // Unmapped reads as zero
        endcase
        return v;
    endfunction : reg_read

    // ------------------------------------------------------------
    // Modulator mapping
    // ------------------------------------------------------------
    tx_symbol_mapper u_mapper (
        .i_enable     (s_q.tx_en),
        .i_mod_type   (s_q.modulation),
        .i_symbol     (s_q.sym),
        .o_pa_on      (map_pa),
        .o_deviation  (map_dev),
        .o_phase_flip (map_flip)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic       rise;
        logic       fall;
        logic [15:0] fr;
        logic [4:0]  k;
        rise = 1'b0;
        fall = 1'b0;
        fr   = 16'h0000;
        k    = 5'h00;

        s_d           = s_q;
        s_d.sclk_prev = i_sclk;
        s_d.bit_take  = 1'b0;
        rise = i_sclk & ~s_q.sclk_prev;
        fall = ~i_sclk & s_q.sclk_prev;

        // Serial frame engine; no power state gates it
        // Access in every state
        if (i_sel_n)
        begin
            s_d.cnt     = 5'h00;
            s_d.miso_oe = 1'b0;
            s_d.miso    = 1'b0;
            s_d.status  = {i_synth_lock, i_fifo_over, i_fifo_under,
                           i_fifo_full, i_fifo_empty, i_fifo_fill_code};
        end
        else
        begin
            s_d.miso_oe = 1'b1;
            if (s_q.cnt == 5'h00 && !s_q.miso_oe)
                s_d.miso = s_q.status[STATUS_BITS-1];
            if (rise && s_q.cnt < 5'(FRAME_BITS))
            begin
                s_d.shift = {i_mosi, s_q.shift[15:1]};
                s_d.cnt   = s_q.cnt + 5'h01;
            end
            if (fall && s_q.cnt < 5'(FRAME_BITS))
            begin
                k = s_q.cnt;
                if (k < 5'(STATUS_BITS))
                    s_d.miso = s_q.status[3'(STATUS_BITS - 1) - k[2:0]];
                else if (k >= 5'(RDATA_FIRST))
                    s_d.miso = s_q.rdata[3'(7) - k[2:0]];
                else
                    s_d.miso = 1'b0;
            end
        end

        if (!i_sel_n && rise && s_q.cnt == 5'(FRAME_BITS - 1))
        begin
            fr = {i_mosi, s_q.shift[15:1]};
            if (fr[DIR_BIT])
            begin
                case (fr[ADDR_LSB +: 7])
                    ADDR_SCRATCH:    s_d.scratch    = fr[DATA_LSB +: 8];
                    ADDR_POWER:      s_d.power      = fr[DATA_LSB +: 4];
                    ADDR_MODULATION: s_d.modulation = fr[DATA_LSB +: 3];
                    ADDR_FRAMING:    s_d.dsss_en    = fr[DATA_LSB + DSSS_EN_BIT];
                    default:         s_d.scratch    = s_q.scratch;
                endcase
            end
            else
            begin
                // Read stages data for the next frame
                s_d.rdata = reg_read(s_q, fr[ADDR_LSB +: 7]);
            end
        end

        // Power state decode; unknown codes fall back to deep sleep
        // Decode power codes
        s_d.core_nominal = 1'b0;
        s_d.serial_slow  = 1'b0;
        s_d.osc_en       = 1'b0;
        s_d.synth_en     = 1'b0;
        s_d.tx_en        = 1'b0;
        case (s_q.power)
            deep_sleep:
            begin
                s_d.serial_slow = 1'b1;
            end
            regulator_on_idle:
            begin
                s_d.core_nominal = 1'b1;
            end
            osc_idle_state:
            begin
                s_d.core_nominal = 1'b1;
                s_d.osc_en       = 1'b1;
            end
            synth_settle_state:
            begin
                s_d.core_nominal = 1'b1;
                s_d.osc_en       = 1'b1;
                s_d.synth_en     = 1'b1;
            end
            // Host must have waited for lock
            full_transmit_state:
            begin
                s_d.core_nominal = 1'b1;
                s_d.osc_en       = 1'b1;
                s_d.synth_en     = 1'b1;
                s_d.tx_en        = 1'b1;
            end
            default:
            begin
                s_d.serial_slow = 1'b1;
            end
        endcase

        // Transmit bit path: symbol or chip per strobe
        if (!s_q.tx_en)
        begin
            s_d.chip = 4'h0;
            s_d.pn   = PN_SEED;
            s_d.sym  = 2'h0;
        end
        else if (i_symbol_tick)
        begin
            if (s_q.dsss_en)
            begin
                // Spread each bit over SPREAD chips
                s_d.sym = {1'b0, i_tx_bits[0] ^ s_q.pn[0]};
                s_d.pn  = {s_q.pn[0] ^ s_q.pn[1], s_q.pn[3:1]};
                if (s_q.chip == 4'(SPREAD - 1))
                begin
                    s_d.chip     = 4'h0;
                    s_d.pn       = PN_SEED;
                    s_d.bit_take = 1'b1;
                end
                else
                begin
                    s_d.chip = s_q.chip + 4'h1;
                end
            end
            else
            begin
                s_d.sym      = i_tx_bits;
                s_d.bit_take = 1'b1;
            end
        end

        // Modulator outputs registered from the mapper
        s_d.pa_on      = map_pa;
        s_d.deviation  = map_dev;
        s_d.phase_flip = map_flip;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            s_q            <= '0;
            s_q.sclk_prev  <= 1'b0;
            s_q.scratch    <= RST_SCRATCH;
            s_q.power      <= RST_POWER;
            s_q.modulation <= RST_MODULATION;
            s_q.pn         <= PN_SEED;
            s_q.serial_slow <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from flip-flops
    // ------------------------------------------------------------
    assign o_miso         = s_q.miso;
    assign o_miso_oe      = s_q.miso_oe;
    assign o_bit_take     = s_q.bit_take;
    assign o_core_nominal = s_q.core_nominal;
    assign o_serial_slow  = s_q.serial_slow;
    assign o_osc_en       = s_q.osc_en;
    assign o_synth_en     = s_q.synth_en;
    assign o_tx_en        = s_q.tx_en;
    assign o_pa_on        = s_q.pa_on;
    assign o_deviation    = s_q.deviation;
    assign o_phase_flip   = s_q.phase_flip;

endmodule : tx_spi_port

// ===== test/tx_host_model.sv
// Host serial master model that shifts frames into the port
`timescale 1ns/1ps
module tx_host_model
(
    input  wire logic i_core_clk, // Core clock, paces the host
    input  wire logic i_miso,     // Device data line
    output logic      o_sclk,     // Serial clock, stands low between frames
    output logic      o_sel_n,    // Frame select, active low
    output logic      o_mosi      // Host data line
);
    // Idle levels before the first frame
    initial
    begin
        o_sclk  = 1'b0;
        o_sel_n = 1'b1;
        o_mosi  = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame transfer; half sets speed, so the host can go slow
    // ------------------------------------------------------------
    // LSB-first frame
    task automatic xfer(input logic [15:0] frame, input int nbits, input int half, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge i_core_clk);
        o_sel_n <= 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            // Data moves only while the clock is low
            @(posedge i_core_clk);
            o_mosi <= frame[i];
            repeat (half) @(posedge i_core_clk);
            // Slot i is settled well after the last fall
            @(negedge i_core_clk);
            rx[15-i] = i_miso;
            @(posedge i_core_clk);
            o_sclk <= 1'b1;
            repeat (half) @(posedge i_core_clk);
            o_sclk <= 1'b0;
        end
        @(posedge i_core_clk);
        o_sel_n <= 1'b1;
        // Released line shows the inverse so stale data never looks valid
        o_mosi  <= ~o_mosi;
        repeat (3) @(posedge i_core_clk);
    endtask : xfer
endmodule : tx_host_model

// ===== test/tx_spi_port_chk.sv
// Concurrent checks on select, data line and power outputs
`timescale 1ns/1ps
module tx_spi_port_chk
    import tx_spi_pkg::*;
#(
    parameter int SPREAD = SPREAD_FACTOR  // Chips per user bit
)
(
    input wire logic i_core_clk,     // Core clock
    input wire logic i_reset,        // Synchronous reset
    input wire logic i_sclk,         // Serial clock
    input wire logic i_sel_n,        // Frame select
    input wire logic i_symbol_tick,  // Symbol strobe
    input wire logic o_miso,         // Device data
    input wire logic o_miso_oe,      // Data drive enable
    input wire logic o_bit_take,     // Bit consumed pulse
    input wire logic o_serial_slow,  // Slow access
    input wire logic o_core_nominal, // Core at nominal
    input wire logic o_osc_en,       // Oscillator on
    input wire logic o_synth_en,     // Synthesizer on
    input wire logic o_tx_en,        // Transmitter on
    input wire logic o_pa_on         // Amplifier on
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    a_oe_on_select: assert property ($fell(i_sel_n) |-> ##[1:3] o_miso_oe)
        else $error("data drive did not start after select");
    a_oe_on_release: assert property ($rose(i_sel_n) |-> ##[1:3] !o_miso_oe)
        else $error("data drive held after frame end");
    a_oe_idle_low: assert property ((i_sel_n [*4]) |-> !o_miso_oe)
        else $error("data driven while not selected");
    // Changes mid-frame only follow a cycle with the clock seen low
    a_miso_after_fall: assert property (o_miso_oe && $past(o_miso_oe) && $changed(o_miso) |-> !$past(i_sclk))
        else $error("data line changed while clock high");

    // ------------------------------------------------------------
    // Power and transmit path
    // ------------------------------------------------------------
    a_sleep_not_nominal: assert property (o_serial_slow |-> !o_core_nominal)
        else $error("slow access with nominal core");
    a_tx_full_chain: assert property (o_tx_en |-> o_synth_en && o_osc_en)
        else $error("transmitter on without synthesizer");
    a_synth_needs_osc: assert property (o_synth_en |-> o_osc_en && !o_serial_slow)
        else $error("synthesizer on without oscillator");
    a_pa_quiet_idle: assert property ((!o_tx_en [*3]) |-> !o_pa_on)
        else $error("amplifier keyed with transmitter off");
    a_take_after_tick: assert property (o_bit_take |-> $past(i_symbol_tick))
        else $error("bit taken without a tick");

    // Main scenarios reached
    cover property ($fell(i_sel_n));
    cover property ($rose(o_tx_en));
    cover property (o_bit_take);
endmodule : tx_spi_port_chk

bind tx_spi_port tx_spi_port_chk #(.SPREAD(SPREAD)) tx_spi_port_chk_i
(
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_sclk(i_sclk), .i_sel_n(i_sel_n),
    .i_symbol_tick(i_symbol_tick), .o_miso(o_miso), .o_miso_oe(o_miso_oe), .o_bit_take(o_bit_take),
    .o_serial_slow(o_serial_slow), .o_core_nominal(o_core_nominal), .o_osc_en(o_osc_en),
    .o_synth_en(o_synth_en), .o_tx_en(o_tx_en), .o_pa_on(o_pa_on)
);

// ===== test/tx_spi_port_power_modes_tb_top.sv
// Self-checking bench for the serial port, power states and modulator
`timescale 1ns/1ps
module tx_spi_port_power_modes_tb_top
    import tx_spi_pkg::*;
;
    typedef struct {logic [6:0] addr; logic [7:0] data; logic tick; logic [1:0] bits;
                    logic [9:0] exp; logic [9:0] mask;} row_t;
    logic i_core_clk, i_reset, i_sclk, i_sel_n, i_mosi;  // Clock, reset, serial lines
    logic i_synth_lock, i_fifo_over, i_fifo_under;       // Status inputs
    logic i_fifo_full, i_fifo_empty, i_symbol_tick;      // Status and strobe
    logic [1:0] i_fifo_fill_code, i_tx_bits;             // Fill code, user bits
    logic o_miso, o_miso_oe, o_bit_take, o_core_nominal, o_serial_slow;
    logic o_osc_en, o_synth_en, o_tx_en, o_pa_on, o_phase_flip;
    logic signed [2:0] o_deviation;                      // Frequency step
    logic [9:0] obs;                                     // Power and modulator view
    logic [15:0] rx;                                     // Slots of last frame
    int miscompares = 0, checks = 0, cycles = 0, takes = 0, n;
    // Power rows walk the session order, an unused code acting as sleep; then each of the five defined modulation codes
    row_t rows [18] = '{
        '{ADDR_POWER, {4'h0, regulator_on_idle}, 1'b0, 2'h0, 10'h100, 10'h3e0},
        '{ADDR_POWER, 8'h0f, 1'b0, 2'h0, 10'h200, 10'h3e0},
        '{ADDR_POWER, {4'h0, deep_sleep}, 1'b0, 2'h0, 10'h200, 10'h3e0},
        '{ADDR_POWER, {4'h0, osc_idle_state}, 1'b0, 2'h0, 10'h180, 10'h3e0},
        '{ADDR_POWER, {4'h0, synth_settle_state}, 1'b0, 2'h0, 10'h1c0, 10'h3e0},
        '{ADDR_POWER, {4'h0, full_transmit_state}, 1'b0, 2'h0, 10'h1e0, 10'h3e0},
        '{ADDR_MODULATION, {5'h00, MOD_ASK}, 1'b1, 2'h0, 10'h000, 10'h010},
        '{ADDR_MODULATION, {5'h00, MOD_ASK}, 1'b1, 2'h1, 10'h010, 10'h010},
        '{ADDR_MODULATION, {5'h00, MOD_PSK}, 1'b1, 2'h0, 10'h000, 10'h001},
        '{ADDR_MODULATION, {5'h00, MOD_PSK}, 1'b1, 2'h1, 10'h001, 10'h001},
        '{ADDR_MODULATION, {5'h00, MOD_FSK}, 1'b1, 2'h0, 10'h00e, 10'h00e},
        '{ADDR_MODULATION, {5'h00, MOD_FSK}, 1'b1, 2'h1, 10'h002, 10'h00e},
        '{ADDR_MODULATION, {5'h00, MOD_MSK}, 1'b1, 2'h0, 10'h00e, 10'h00e},
        '{ADDR_MODULATION, {5'h00, MOD_MSK}, 1'b1, 2'h1, 10'h002, 10'h00e},
        '{ADDR_MODULATION, {5'h00, MOD_FSK4}, 1'b1, 2'h0, 10'h00a, 10'h00e},
        '{ADDR_MODULATION, {5'h00, MOD_FSK4}, 1'b1, 2'h1, 10'h00e, 10'h00e},
        '{ADDR_MODULATION, {5'h00, MOD_FSK4}, 1'b1, 2'h2, 10'h002, 10'h00e},
        '{ADDR_MODULATION, {5'h00, MOD_FSK4}, 1'b1, 2'h3, 10'h006, 10'h00e}};

    assign obs = {o_serial_slow, o_core_nominal, o_osc_en, o_synth_en, o_tx_en, o_pa_on, o_deviation, o_phase_flip};

    // Short spread so the chip count stays quick to walk
    tx_spi_port #(.SPREAD(3)) tx_spi_port_i
    (
        .i_core_clk(i_core_clk), .i_reset(i_reset), .i_sclk(i_sclk), .i_sel_n(i_sel_n),
        .i_mosi(i_mosi), .o_miso(o_miso), .o_miso_oe(o_miso_oe), .i_synth_lock(i_synth_lock),
        .i_fifo_over(i_fifo_over), .i_fifo_under(i_fifo_under), .i_fifo_full(i_fifo_full),
        .i_fifo_empty(i_fifo_empty), .i_fifo_fill_code(i_fifo_fill_code), .i_symbol_tick(i_symbol_tick),
        .i_tx_bits(i_tx_bits), .o_bit_take(o_bit_take), .o_core_nominal(o_core_nominal),
        .o_serial_slow(o_serial_slow), .o_osc_en(o_osc_en), .o_synth_en(o_synth_en), .o_tx_en(o_tx_en),
        .o_pa_on(o_pa_on), .o_deviation(o_deviation), .o_phase_flip(o_phase_flip)
    );
    tx_host_model tx_host_model_i
    (
        .i_core_clk(i_core_clk), .i_miso(o_miso), .o_sclk(i_sclk), .o_sel_n(i_sel_n), .o_mosi(i_mosi)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Deep sleep only allows slow access, so the host slows down there
    task automatic access(input logic wr, input logic [6:0] addr, input logic [7:0] data, output logic [15:0] q);
        tx_host_model_i.xfer({wr, addr, data}, 16, o_serial_slow ? 6 : 3, q);
    endtask : access
    // Read data trails one frame, so the address is read twice
    task automatic rd(input logic [6:0] addr, output logic [15:0] q);
        access(1'b0, addr, 8'h00, q);
        access(1'b0, addr, 8'h00, q);
    endtask : rd
    task automatic pulse(input logic [1:0] b);
        @(posedge i_core_clk);
        i_symbol_tick <= 1'b1;
        i_tx_bits     <= b;
        @(posedge i_core_clk);
        i_symbol_tick <= 1'b0;
        repeat (4) @(posedge i_core_clk);
    endtask : pulse
    task automatic end_sim();
        if (miscompares == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_sim

    initial
    begin
        i_core_clk = 1'b0;
        forever #25 i_core_clk = ~i_core_clk;
    end
    // Cycle ceiling well above the expected run length; also counts takes
    always @(posedge i_core_clk)
    begin
        cycles++;
        if (o_bit_take === 1'b1 && !i_reset)
            takes++;
        if (cycles == 40000)
        begin
            miscompares++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        i_reset = 1'b1;
        i_synth_lock = 1'b1;
        i_fifo_over = 1'b0;
        i_fifo_under = 1'b1;
        i_fifo_full = 1'b0;
        i_fifo_empty = 1'b1;
        i_fifo_fill_code = 2'h2;
        i_symbol_tick = 1'b0;
        i_tx_bits = 2'h0;
        repeat (12) @(posedge i_core_clk);
        i_reset <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        @(negedge i_core_clk);
        check({5'h00, o_miso_oe, obs}, 16'h0200);
        rd(ADDR_POWER, rx);
        check({8'h00, rx[7:0]}, 16'h0000);
        // Write in deep sleep at slow speed; status rides along
        access(1'b1, ADDR_SCRATCH, 8'ha5, rx);
        check({rx[15:8], 8'h00}, 16'hac00);
        rd(ADDR_SCRATCH, rx);
        check(rx, 16'haca5);
        // host steps the power field in session order, then the modulation code
        foreach (rows[r])
        begin
            access(1'b1, rows[r].addr, rows[r].data, rx);
            if (rows[r].tick)
                pulse(rows[r].bits);
            repeat (4) @(posedge i_core_clk);
            @(negedge i_core_clk);
            check({6'h00, obs & rows[r].mask}, {6'h00, rows[r].exp});
        end
        check(16'(takes), 16'h000c);
        rd(7'h7f, rx);
        check({8'h00, rx[7:0]}, 16'h0000);
        // Frame cut short one bit early must not write
        tx_host_model_i.xfer({1'b1, ADDR_SCRATCH, 8'h3c}, 15, 3, rx);
        rd(ADDR_SCRATCH, rx);
        check({8'h00, rx[7:0]}, 16'h00a5);
        // Spread mode takes one user bit per three chips
        // chip strobes stay far apart, well inside the rate limit
        access(1'b1, ADDR_FRAMING, 8'h01, rx);
        n = takes;
        repeat (6) pulse(2'h1);
        check(16'(takes - n), 16'h0002);
        // Reset in mid-run returns to deep sleep
        @(posedge i_core_clk);
        i_reset <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_reset <= 1'b0;
        @(negedge i_core_clk);
        check({6'h00, obs}, 16'h0200);
        @(negedge i_core_clk);
        check({5'h00, o_miso_oe, obs}, 16'h0200);
        end_sim();
    end
endmodule : tx_spi_port_power_modes_tb_top
